/* src/txlink_pkg.sv */
package txlink_pkg;

    localparam int unsigned CLOCK_HZ      = 25_000_000;
    localparam int unsigned BITS_PER_CHAR = 10;
    localparam logic [3:0]  LAST_PHASE    = 4'(BITS_PER_CHAR - 1);
    // Read pulse low share, percent
    localparam int unsigned RP_LOW_PCT    = 60;
    localparam logic [3:0]  RP_LOW_PHASES = 4'((BITS_PER_CHAR * RP_LOW_PCT) / 100);

    localparam logic [7:0]  PAD_DATA      = 8'hBC;
    localparam logic [7:0]  C07_DATA      = 8'hE0;
    // Six ones up front: never legal
    localparam logic [9:0]  VIOL_CODE_NEG = 10'h3F0;
    localparam logic [5:0]  K28_SIX_NEG   = 6'h0F;
    localparam logic [3:0]  ALT7_NEG      = 4'h7;
    localparam logic        RD_RESET      = 1'b0;

    localparam int unsigned ADDR_W          = 4;
    localparam logic [3:0]  CTRL_OFFSET     = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET   = 4'h4;
    localparam logic [3:0]  PAD_CNT_OFFSET  = 4'h8;
    localparam int unsigned CTRL_BYPASS_BIT = 0;
    localparam int unsigned STAT_RD_BIT     = 0;
    localparam int unsigned STAT_PAD_BIT    = 1;
    localparam int unsigned STAT_BYPASS_BIT = 2;
    localparam logic        CTRL_RESET      = 1'b0;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

/* src/char_encoder.sv */
`timescale 1ns/1ps
module char_encoder (
    input  wire logic [7:0] data,
    input  wire logic       k,
    input  wire logic       force_viol,
    input  wire logic       rd_in,
    output logic      [9:0] code,
    output logic            rd_out
);

    function automatic logic [5:0] six_neg(input logic [4:0] x);
        logic [5:0] t [32];
        t = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
              6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
              6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
              6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
        return t[x];
    endfunction

    function automatic logic [3:0] four_neg(input logic [2:0] y);
        logic [3:0] t [8];
        t = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
        return t[y];
    endfunction

    function automatic logic [2:0] ones(input logic [5:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 6; i++) begin
            n = n + 3'(v[i]);
        end
        return n;
    endfunction

    logic [4:0] x5;
    logic [2:0] y3;
    logic       k28;
    logic       kx7;
    logic       viol;
    logic [5:0] c6;
    logic       unb6;
    logic       rd6;
    logic       alt7;
    logic [3:0] c4;
    logic       unb4;
    logic       flip4;

    always_comb begin
        x5   = data[4:0];
        y3   = data[7:5];
        k28  = k && (x5 == 5'h1C);
        kx7  = k && (y3 == 3'h7) && (x5 == 5'h17 || x5 == 5'h1B || x5 == 5'h1D || x5 == 5'h1E);
        // Unknown specials also go out as violations
        viol = force_viol || (k && data == txlink_pkg::C07_DATA)      // [RULE7] [RULE8]
               || (k && !(k28 || kx7));
        c6   = k28 ? txlink_pkg::K28_SIX_NEG : six_neg(x5);               // [RULE6]
        unb6 = ones(c6) != 3'h3;
        if (rd_in && (unb6 || (x5 == 5'h07 && !k28))) begin             // [RULE17]
            c6 = ~c6;
        end
        rd6  = rd_in ^ unb6;
        alt7 = (y3 == 3'h7) && (k28 || kx7
               || (!rd6 && (x5 == 5'h11 || x5 == 5'h12 || x5 == 5'h14))
               || (rd6 && (x5 == 5'h0B || x5 == 5'h0D || x5 == 5'h0E)));
        c4   = alt7 ? txlink_pkg::ALT7_NEG : four_neg(y3);
        unb4 = ones({2'h0, c4}) != 3'h2;
        if (rd6) begin
            flip4 = unb4 || (y3 == 3'h3);
        end else begin
            flip4 = k28 && (y3 == 3'h1 || y3 == 3'h2 || y3 == 3'h5 || y3 == 3'h6);
        end
        if (flip4) begin
            c4 = ~c4;
        end
        if (viol) begin
            code   = rd_in ? ~txlink_pkg::VIOL_CODE_NEG : txlink_pkg::VIOL_CODE_NEG;
            rd_out = rd_in;
        end else begin
            code   = {c6, c4};
            rd_out = rd6 ^ unb4;
        end
    end

endmodule

/* src/serial_8b10b_link_transmitter.sv */
`timescale 1ns/1ps
// Function
// RULE1 - Capture byte on byte edge when strobe low
// RULE2 - Read pulse 60% low while primary strobe low
// RULE3 - Ten bit clocks per byte clock
// RULE4 - Input to output latency about 21 bits
// RULE5 - Encoded input: data, context, force
// RULE6 - Context selects data or special code set
// RULE7 - Special C0.7 sends violation symbol
// RULE8 - Force input replaces code with violation
// RULE9 - Bypass: context a, data b-h, force j (code puts the eight data bits in b-i)
// RULE10 - Bypass sends ten bits unchanged
// RULE11 - Bypass source keeps transitions
// RULE12 - Captured char enters shifter next byte edge
// RULE13 - Bit a first, on all three pairs
// RULE14 - Both strobes high inserts K28.5 pad
// RULE15 - Later pads carry correct disparity
// RULE16 - Hold a strobe low to avoid pads
// RULE17 - Encoded mode tracks running disparity
// RULE18 - Mode is static, set by system
module serial_8b10b_link_transmitter (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          byte_clock_in,
    input  wire logic                          load_strobe_primary_n,
    input  wire logic                          load_strobe_next_n,
    input  wire logic [7:0]                    data_in,
    input  wire logic                          char_context_sel,
    input  wire logic                          force_violation_in,
    output logic                               read_pulse_out_n,
    output logic                               serial_out_pair_first_pos,
    output logic                               serial_out_pair_first_neg,
    output logic                               serial_out_pair_second_pos,
    output logic                               serial_out_pair_second_neg,
    output logic                               serial_out_pair_third_pos,
    output logic                               serial_out_pair_third_neg,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [txlink_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                    awprot,
    input  wire logic                          wvalid,
    output logic                               wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    output logic                               bvalid,
    input  wire logic                          bready,
    output logic [1:0]                         bresp,
    input  wire logic                          arvalid,
    output logic                               arready,
    input  wire logic [txlink_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                    arprot,
    output logic                               rvalid,
    input  wire logic                          rready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp
);

    function automatic logic reg_known(input logic [txlink_pkg::ADDR_W-1:0] a);
        return a == txlink_pkg::CTRL_OFFSET || a == txlink_pkg::STATUS_OFFSET
            || a == txlink_pkg::PAD_CNT_OFFSET;
    endfunction

    // Byte clock timing
    logic       byte_prev_q;
    logic       byte_edge;
    logic [3:0] phase_q;
    logic [3:0] phase_d;

    // Read pulse
    logic       rp_n_q;

    // Capture stage
    logic [7:0] in_data_q;
    logic       in_ctx_q;
    logic       in_force_q;
    logic       in_pad_q;
    logic       in_bypass_q;

    // Encode stage
    logic [7:0] enc_data;
    logic       enc_k;
    logic       enc_force;
    logic [9:0] enc_code;
    logic       enc_rd;

    // Shift stage
    logic [9:0] char_q;
    logic       rd_q;
    logic       last_pad_q;
    logic [8:0] shift_q;
    logic       out_q;
    logic       out_bar_q;
    logic [31:0] pad_cnt_q;

    // Register slave
    logic        bypass_q;
    logic        aw_hold_q;
    logic [3:0]  aw_addr_q;
    logic        w_hold_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        do_write;

    // Read side
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] read_word;

    // Byte edge realigns the bit phase
    assign byte_edge = byte_clock_in && !byte_prev_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            byte_prev_q <= 1'b0;
        end else begin
            byte_prev_q <= byte_clock_in;
        end
    end

    always_comb begin
        if (byte_edge) begin
            phase_d = 4'h0;                                             // [RULE3]
        end else if (phase_q < txlink_pkg::LAST_PHASE) begin
            phase_d = phase_q + 4'h1;                                   // [RULE3]
        end else begin
            phase_d = phase_q;
        end
    end

    // Bit phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Low six phases, high four
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rp_n_q <= 1'b1;
        end else begin
            rp_n_q <= load_strobe_primary_n
                      || (phase_d >= txlink_pkg::RP_LOW_PHASES);        // [RULE2]
        end
    end

    assign read_pulse_out_n = rp_n_q;

    // No strobe: data held, pad flagged
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_data_q   <= 8'h00;
            in_ctx_q    <= 1'b0;
            in_force_q  <= 1'b0;
            in_pad_q    <= 1'b1;
            in_bypass_q <= txlink_pkg::CTRL_RESET;
        end else if (byte_edge) begin
            in_pad_q    <= load_strobe_primary_n && load_strobe_next_n; // [RULE14]
            in_bypass_q <= bypass_q;
            if (!load_strobe_primary_n || !load_strobe_next_n) begin
                in_data_q  <= data_in;                                  // [RULE1] [RULE5]
                in_ctx_q   <= char_context_sel;                         // [RULE1]
                in_force_q <= force_violation_in;                       // [RULE1]
            end
        end
    end

    // Pads are encoded in both modes
    always_comb begin
        if (in_pad_q) begin
            enc_data  = txlink_pkg::PAD_DATA;                           // [RULE14]
            enc_k     = 1'b1;
            enc_force = 1'b0;
        end else begin
            enc_data  = in_data_q;                                      // [RULE5]
            enc_k     = in_ctx_q;                                       // [RULE6]
            enc_force = in_force_q;                                     // [RULE8]
        end
    end

    char_encoder u_char_encoder (
        .data       (enc_data),
        .k          (enc_k),
        .force_viol (enc_force),
        .rd_in      (rd_q),
        .code       (enc_code),
        .rd_out     (enc_rd)
    );

    // Bypass keeps disparity, so the first
    // pad after it may take either sense
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            char_q     <= txlink_pkg::VIOL_CODE_NEG;
            rd_q       <= txlink_pkg::RD_RESET;
            last_pad_q <= 1'b0;
        end else if (byte_edge) begin
            last_pad_q <= in_pad_q;
            if (in_bypass_q && !in_pad_q) begin
                char_q <= {in_ctx_q, in_data_q[0], in_data_q[1], in_data_q[2],
                           in_data_q[3], in_data_q[4], in_data_q[5], in_data_q[6],
                           in_data_q[7], in_force_q};                   // [RULE9] [RULE10] [RULE12]
            end else begin
                char_q <= enc_code;                                     // [RULE12] [RULE17]
                rd_q   <= enc_rd;                                       // [RULE15] [RULE17]
            end
        end
    end

    // Bit a on the same edge as load
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_q   <= 9'h000;
            out_q     <= 1'b0;
            out_bar_q <= 1'b1;
        end else if (byte_edge) begin
            shift_q   <= char_q[8:0];                                   // [RULE4]
            out_q     <= char_q[9];                                     // [RULE13]
            out_bar_q <= !char_q[9];
        end else begin
            shift_q   <= {shift_q[7:0], 1'b0};                          // [RULE12]
            out_q     <= shift_q[8];
            out_bar_q <= !shift_q[8];
        end
    end

    // One flop pair feeds all three
    assign serial_out_pair_first_pos  = out_q;                          // [RULE13]
    assign serial_out_pair_first_neg  = out_bar_q;
    assign serial_out_pair_second_pos = out_q;
    assign serial_out_pair_second_neg = out_bar_q;
    assign serial_out_pair_third_pos  = out_q;
    assign serial_out_pair_third_neg  = out_bar_q;

    // Pad count wraps
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pad_cnt_q <= 32'h0000_0000;
        end else if (byte_edge && in_pad_q) begin
            pad_cnt_q <= pad_cnt_q + 32'h0000_0001;
        end
    end

    // Address and data in either order
    assign awready  = !aw_hold_q;
    assign wready   = !w_hold_q;
    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

    // Address half
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end
    end

    // Data half
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w_hold_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end
    end

    // Mode change lands at next capture
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bypass_q <= txlink_pkg::CTRL_RESET;
        end else if (do_write && aw_addr_q == txlink_pkg::CTRL_OFFSET
                     && w_strb_q[0]) begin
            bypass_q <= w_data_q[txlink_pkg::CTRL_BYPASS_BIT];          // [RULE18]
        end
    end

    // Unmapped: SLVERR
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q  <= txlink_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= reg_known(aw_addr_q) ? txlink_pkg::RESP_OKAY
                                             : txlink_pkg::RESP_SLVERR;
        end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Response
    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;

    // Read channel
    always_comb begin
        read_word = 32'h0000_0000;
        unique case (araddr)
            txlink_pkg::CTRL_OFFSET: begin
                read_word[txlink_pkg::CTRL_BYPASS_BIT] = bypass_q;
            end
            txlink_pkg::STATUS_OFFSET: begin
                read_word[txlink_pkg::STAT_RD_BIT]     = rd_q;
                read_word[txlink_pkg::STAT_PAD_BIT]    = last_pad_q;
                read_word[txlink_pkg::STAT_BYPASS_BIT] = in_bypass_q;
            end
            txlink_pkg::PAD_CNT_OFFSET: begin
                read_word = pad_cnt_q;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    assign arready = !rvalid_q;

    // Registered read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= txlink_pkg::RESP_OKAY;
        end else if (arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= read_word;
            rresp_q  <= reg_known(araddr) ? txlink_pkg::RESP_OKAY
                                          : txlink_pkg::RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;

endmodule

/* test/txlink_sva.sv */
`timescale 1ns/1ps
module txlink_sva (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        byte_clock_in,
    input wire logic        load_strobe_primary_n,
    input wire logic        read_pulse_out_n,
    input wire logic        serial_out_pair_first_pos,
    input wire logic        serial_out_pair_first_neg,
    input wire logic        serial_out_pair_second_pos,
    input wire logic        serial_out_pair_third_pos,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata
);
    logic       prev_q;
    logic       seen_q;
    logic       rp_exp_q;
    logic [3:0] ph_q;
    logic [3:0] ph;
    logic       bedge;
    assign bedge = byte_clock_in && !prev_q;
    // Parks at 9 if the byte clock is late
    assign ph = bedge ? 4'h0 : ((ph_q == 4'h9) ? 4'h9 : ph_q + 4'h1);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_q   <= 1'b0;
            seen_q   <= 1'b0;
            rp_exp_q <= 1'b1;
            ph_q     <= 4'h9;
        end else begin
            prev_q   <= byte_clock_in;
            seen_q   <= seen_q | bedge;
            rp_exp_q <= load_strobe_primary_n | (ph >= 4'h6);
            ph_q     <= ph;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence aw_w_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence ar_taken;
        arvalid && arready;
    endsequence
    AST_RP_DUTY: assert property (read_pulse_out_n == rp_exp_q)
        else $error("read pulse duty wrong");
    AST_RP_LOW_START: assert property (bedge && !load_strobe_primary_n |=> !read_pulse_out_n)
        else $error("read pulse not low");
    AST_PAIR_COPY: assert property (serial_out_pair_second_pos == serial_out_pair_first_pos
        && serial_out_pair_third_pos == serial_out_pair_first_pos)
        else $error("serial pairs differ");
    AST_PAIR_COMPL: assert property (serial_out_pair_first_neg != serial_out_pair_first_pos)
        else $error("pair not complementary");
    AST_IDLE_UNTIL_BYTE: assert property (!seen_q |-> !serial_out_pair_first_pos)
        else $error("serial moved early");
    AST_WRITE_RESP: assert property (aw_w_taken |-> ##2 bvalid)
        else $error("no write response");
    AST_BVALID_HOLD: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    AST_READ_RESP: assert property (ar_taken |=> rvalid)
        else $error("no read response");
    AST_RDATA_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    AST_AR_BLOCK: assert property (rvalid |-> !arready)
        else $error("read address taken while busy");
endmodule

bind serial_8b10b_link_transmitter txlink_sva chk (.*);

/* test/byte_source_model.sv */
`timescale 1ns/1ps
module byte_source_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       byte_clock_in,
    input  wire logic       use_next,
    output logic      [7:0] data_in,
    output logic            char_context_sel,
    output logic            force_violation_in,
    output logic            load_strobe_primary_n,
    output logic            load_strobe_next_n
);
    logic [9:0] q[$];
    logic       prev_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_q                <= 1'b0;
            data_in               <= 8'h00;
            char_context_sel      <= 1'b0;
            force_violation_in    <= 1'b0;
            load_strobe_primary_n <= 1'b1;
            load_strobe_next_n    <= 1'b1;
        end else begin
            prev_q <= byte_clock_in;
            if (byte_clock_in && !prev_q) begin
                if (q.size() != 0) begin
                    {char_context_sel, data_in, force_violation_in} <= q.pop_front();
                    load_strobe_primary_n <= use_next;
                    load_strobe_next_n    <= !use_next;
                end else begin
                    // Idle: inverse of last byte
                    data_in               <= ~data_in;
                    load_strobe_primary_n <= 1'b1;
                    load_strobe_next_n    <= 1'b1;
                end
            end
        end
    end
endmodule

/* test/test_serial_8b10b_link_transmitter.sv */
`timescale 1ns/1ps
module test_serial_8b10b_link_transmitter;
    typedef struct packed {logic byp; logic [7:0] d; logic k; logic f; logic [9:0] c;} row_s;
    logic        clock, rst_n, byte_clock_in, use_next, byp_mode, prev_b, started, rd, loose;
    logic        load_strobe_primary_n, load_strobe_next_n, char_context_sel, force_violation_in;
    logic        read_pulse_out_n, serial_out_pair_first_pos, serial_out_pair_first_neg;
    logic        serial_out_pair_second_pos, serial_out_pair_second_neg;
    logic        serial_out_pair_third_pos, serial_out_pair_third_neg;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, resp;
    logic [2:0]  awprot, arprot;
    logic [3:0]  awaddr, araddr, wstrb, bc;
    logic [7:0]  data_in;
    logic [9:0]  sh, e, got;
    logic [31:0] wdata, rdata, val;
    int          n_fail, check_count;
    row_s        r;
    row_s        exp_q[$];
    row_s        rows[8] = '{
        '{1'b0, 8'hBC, 1'b1, 1'b0, 10'h0FA},
        '{1'b0, 8'h00, 1'b0, 1'b0, 10'h274},
        '{1'b0, 8'h1C, 1'b1, 1'b0, 10'h0F4},
        '{1'b0, 8'h00, 1'b0, 1'b1, txlink_pkg::VIOL_CODE_NEG},
        '{1'b0, 8'hE0, 1'b1, 1'b0, txlink_pkg::VIOL_CODE_NEG},
        '{1'b0, 8'hF7, 1'b1, 1'b0, 10'h3A8},
        '{1'b1, 8'h5A, 1'b1, 1'b0, 10'h2B4},
        '{1'b1, 8'h0F, 1'b0, 1'b1, 10'h1E1}};

    serial_8b10b_link_transmitter dut (.*);
    byte_source_model src (.*);

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bc            <= 4'h0;
            byte_clock_in <= 1'b0;
        end else begin
            bc            <= (bc == 4'h9) ? 4'h0 : bc + 4'h1;
            byte_clock_in <= (bc < 4'h5);
        end
    end

    function automatic logic [9:0] code_of(row_s x);
        code_of = txlink_pkg::VIOL_CODE_NEG;
        foreach (rows[i])
            if (rows[i][20:10] === x[20:10]) code_of = rows[i].c;
    endfunction
    task automatic chk_val(string nm, logic [31:0] ex, logic [31:0] g);
        check_count++;
        if (g !== ex) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic chk_char(logic [9:0] ex, logic [9:0] g);
        chk_val("serial char", 32'(ex), 32'(g));
    endtask

    always @(posedge clock) begin
        if (rst_n) begin
            prev_b <= byte_clock_in;
            sh     <= {sh[8:0], serial_out_pair_first_pos};
            if (byte_clock_in && !prev_b) begin
                if (load_strobe_primary_n && load_strobe_next_n)
                    exp_q.push_back({1'b0, txlink_pkg::PAD_DATA, 1'b1, 1'b0, 10'h000});
                else
                    exp_q.push_back({byp_mode, data_in, char_context_sel, force_violation_in,
                                     10'h000});
                if (started) begin
                    r   = exp_q.pop_front();
                    e   = code_of(r);
                    got = {sh[8:0], serial_out_pair_first_pos};
                    if (!r.byp && rd)
                        e = ~e;
                    // First pad after bypass: either sense
                    if (loose && !r.byp && got === ~e) begin
                        e  = ~e;
                        rd = !rd;
                    end
                    chk_char(e, got);
                    if (!r.byp && code_of(r) !== txlink_pkg::VIOL_CODE_NEG && $countones(e) != 5)
                        rd = !rd;
                    loose = r.byp;
                end
                started = 1'b1;
            end
        end
    end

    task automatic axi_wr(logic [3:0] a, logic [31:0] d);
        @(posedge clock);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(logic [3:0] a);
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        val = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic flush();
        for (int n = 0; n < 500 && src.q.size() != 0; n++)
            @(posedge clock);
        repeat (60) @(posedge clock);
    endtask
    task automatic do_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        @(posedge clock);
        exp_q = '{{1'b0, txlink_pkg::C07_DATA, 1'b1, 1'b0, 10'h000},
                  {1'b0, txlink_pkg::PAD_DATA, 1'b1, 1'b0, 10'h000}};
        started = 1'b0;
        rd      = txlink_pkg::RD_RESET;
        loose   = 1'b0;
        repeat (6) @(posedge clock);
        chk_val("reset outputs", 32'hBC, {24'h0, read_pulse_out_n, serial_out_pair_first_pos,
                serial_out_pair_first_neg, awready, wready, arready, bvalid, rvalid});
        rst_n <= 1'b1;
        $display("test reset done, failures %0d", n_fail);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        conclude();
    end
    initial begin
        {rst_n, use_next, byp_mode, prev_b, awvalid, wvalid, bready, arvalid, rready} = 9'h000;
        {awprot, arprot, awaddr, araddr, wdata, sh} = 56'h0;
        wstrb       = 4'hF;
        n_fail      = 0;
        check_count = 0;
        do_reset();
        for (int p = 0; p < 2; p++) begin
            axi_wr(txlink_pkg::CTRL_OFFSET, 32'(p));
            chk_val("ctrl write resp", 32'(txlink_pkg::RESP_OKAY), 32'(resp));
            byp_mode = p[0];
            foreach (rows[i])
                if (rows[i].byp == p[0])
                    src.q.push_back({rows[i].k, rows[i].d, rows[i].f});
            flush();
            $display("test rows pass %0d done, failures %0d", p, n_fail);
        end
        axi_rd(txlink_pkg::CTRL_OFFSET);
        chk_val("ctrl readback", 32'h1, val);
        axi_wr(txlink_pkg::CTRL_OFFSET, 32'h0);
        byp_mode = 1'b0;
        use_next <= 1'b1;
        src.q.push_back({1'b0, 8'h00, 1'b0});
        src.q.push_back({1'b1, 8'hBC, 1'b0});
        flush();
        use_next <= 1'b0;
        $display("test second strobe done, failures %0d", n_fail);
        axi_rd(4'hC);
        chk_val("unmapped read resp", 32'(txlink_pkg::RESP_SLVERR), 32'(resp));
        chk_val("unmapped read data", 32'h0, val);
        axi_wr(4'hC, 32'h1);
        chk_val("unmapped write resp", 32'(txlink_pkg::RESP_SLVERR), 32'(resp));
        axi_wr(txlink_pkg::CTRL_OFFSET, 32'h1);
        do_reset();
        axi_rd(txlink_pkg::CTRL_OFFSET);
        chk_val("ctrl after reset", 32'h0, val);
        flush();
        $display("test regs and reset done, failures %0d", n_fail);
        conclude();
    end
endmodule
